// File: qwsc_pkg.sv
// What this block does
// - Frame is 24 bits, fixed field order
// - Bits move most significant first
// - Sample on rising clock, drive on falling
// - Chip select rising edge executes the frame
// - Two channel bits pick channel 0 to 3
// - Two slot bits pick slot 0 to 3
// - Buffer bit 0 off, 1 on, per channel
// - Only slot load and boot recall change buffer mode
// - Four 9-bit slots; slot 0 recalled at boot
// - Step up/down by one, saturating
// - Program writes frame's nine bits to slot
// - Save copies wiper and buffer to slot
// - Write protect blocks slot changes, not reads
// - Ready high from chip select fall when idle
// - Slot access cycle runs before next command
// - Acts as 24-bit chain shift register
// - First output bit appears at select fall
// - Wake, sleep, reset and no-op opcodes
// - Asleep after boot, reset, sleep; only wake
// - Write, up, down and load opcodes
package qwsc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int NUM_CHAN = 4;
    localparam int NUM_SLOT = 4;
    localparam int NV_BITS = 9;

    // Field layout of one frame, most significant first
    typedef struct packed {
        logic [3:0] opcode_field;
        logic [1:0] slot_sel;
        logic [1:0] channel_sel;
        logic [6:0] unused_bits;
        logic buffer_mode_bit;
        logic [7:0] wiper_data_byte;
    } qwsc_frame_t;

    // One retained word: buffer mode on top of the wiper value
    typedef struct packed {
        logic buffer_mode_bit;
        logic [7:0] wiper_data_byte;
    } qwsc_nv_word_t;

    // Opcode encodings
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_WAKE = 4'h1;
    localparam logic [3:0] OP_PROG = 4'h2;
    localparam logic [3:0] OP_SAVE = 4'h3;
    localparam logic [3:0] OP_WRITE = 4'h4;
    localparam logic [3:0] OP_UP = 4'h7;
    localparam logic [3:0] OP_SLEEP = 4'h8;
    localparam logic [3:0] OP_SWPOR = 4'h9;
    localparam logic [3:0] OP_RD_SLOT = 4'hA;
    localparam logic [3:0] OP_LOAD = 4'hB;
    localparam logic [3:0] OP_RD_WIPER = 4'hC;
    localparam logic [3:0] OP_ERASE = 4'hD;
    localparam logic [3:0] OP_DOWN = 4'hF;

    // Scale ends of the wiper
    localparam logic [7:0] WIPER_MAX = 8'hFF;
    localparam logic [7:0] WIPER_MIN = 8'h00;
    localparam logic [7:0] WIPER_RESET = 8'h00;

    // Content of a never-written or erased slot
    localparam logic [8:0] NV_ERASED = 9'h000;

    // Bit count at which a full frame has arrived
    localparam logic [4:0] BIT_COUNT_FULL = 5'h18;
    localparam logic [4:0] BIT_COUNT_ONE = 5'h01;

    // Internal slot access time
    localparam int SYS_CLK_MHZ = 100;
    localparam int ACCESS_TIME_NS = 1000;
    localparam int ACCESS_CYCLES = (ACCESS_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] ACCESS_LAST = 8'(ACCESS_CYCLES - 1);

    // Control states of the command engine
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } qwsc_state_t;
endpackage

// File: qwsc_nvstore.sv
// Four slots for each of four channels, one write port, one read port
module qwsc_nvstore
    import qwsc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic [3:0] i_rd_addr,
    output qwsc_nv_word_t o_rd_data,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_addr,
    input wire qwsc_nv_word_t i_wr_data
);
    // Address is slot index above channel index
    qwsc_nv_word_t mem [NUM_SLOT*NUM_CHAN];

    // Retained contents survive reset, so no reset here
    initial begin
        for (int i = 0; i < NUM_SLOT*NUM_CHAN; i++) begin
            mem[i] = NV_ERASED;
        end
    end

    // Registered write
    always_ff @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // Read is plain array access; callers hold the address stable
    assign o_rd_data = mem[i_rd_addr];
endmodule

// File: qwsc_link.sv
// Serial shift logic, clocked by the host's serial clock
module qwsc_link
    import qwsc_pkg::*;
(
    input wire logic i_spi_clk,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_preload_en,
    input wire qwsc_nv_word_t i_preload,
    output qwsc_frame_t o_frame,
    output logic o_full,
    output logic o_sdo_o,
    output logic o_sdo_oe
);
    logic [23:0] shreg_r; // Chain shift register
    logic [23:0] shreg_nxt;
    logic [4:0] cnt_r; // Bits seen this frame, saturating
    logic [4:0] cnt_nxt;
    logic fresh_r; // No rising edge yet in this frame
    logic sdo_neg_r; // Bit driven since the last falling edge
    logic seen_neg_r; // A falling edge has passed this frame
    logic frame_rst; // Frame-local reset while deselected
    logic sdo_bit;

    assign frame_rst = i_reset | i_cs_n;

    // Shift in at the LSB end; read data merges on the first edge
    always_comb begin
        shreg_nxt = shreg_r;
        if (fresh_r && i_preload_en) begin
            shreg_nxt[8:0] = i_preload;
        end
        shreg_nxt = {shreg_nxt[22:0], i_sdi};
        cnt_nxt = fresh_r ? BIT_COUNT_ONE : cnt_r;
        if (!fresh_r && cnt_r != BIT_COUNT_FULL) begin
            cnt_nxt = cnt_r + BIT_COUNT_ONE;
        end
    end

    // Held frame and its bit count survive deselect: the engine reads the
    // count after select rises, and the frame is shifted out next time
    always_ff @(posedge i_spi_clk or posedge i_reset) begin
        if (i_reset) begin
            shreg_r <= 24'h000000;
            cnt_r <= 5'h00;
        end else begin
            shreg_r <= shreg_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Per-frame marker is set while chip select is high; the count restarts
    // from it at the first rising edge of the next frame
    always_ff @(posedge i_spi_clk or posedge frame_rst) begin
        if (frame_rst) begin
            fresh_r <= 1'b1;
        end else begin
            fresh_r <= 1'b0;
        end
    end

    // Registered output bit changes only on falling clock edges
    always_ff @(negedge i_spi_clk or posedge frame_rst) begin
        if (frame_rst) begin
            sdo_neg_r <= 1'b1;
            seen_neg_r <= 1'b0;
        end else begin
            sdo_neg_r <= shreg_r[23];
            seen_neg_r <= 1'b1;
        end
    end

    // Before the first falling edge the held MSB shows directly
    assign sdo_bit = seen_neg_r ? sdo_neg_r : shreg_r[23];
    // Open drain: enable only to pull low while selected
    assign o_sdo_o = 1'b0;
    assign o_sdo_oe = !i_cs_n && !sdo_bit;
    assign o_frame = shreg_r;
    assign o_full = (cnt_r == BIT_COUNT_FULL);
endmodule

// File: qwsc_core.sv
// Quad wiper serial command engine, top level
module qwsc_core
    import qwsc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_spi_clk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_wp_n,
    output logic o_sdo_o,
    output logic o_sdo_oe,
    output logic o_ready,
    output logic o_asleep,
    output logic [31:0] o_wiper_value,
    output logic [3:0] o_buffer_on
);
    // Input synchronisers; stage one feeds stage two only
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_d_r; // Delayed copy for edge detection
    logic wp_s1_r;
    logic wp_s2_r;

    // Engine state
    qwsc_state_t state_r;
    qwsc_state_t state_nxt;
    logic [7:0] cnt_r; // Access cycle timer
    logic [7:0] cnt_nxt;
    logic [1:0] boot_idx_r; // Channel being recalled
    logic [1:0] boot_idx_nxt;
    logic [3:0][7:0] wiper_r; // wiper_value_reg per channel
    logic [3:0][7:0] wiper_nxt;
    logic [3:0] bufm_r; // Buffer mode per channel
    logic [3:0] bufm_nxt;
    logic asleep_r;
    logic asleep_nxt;
    logic ready_r;
    logic ready_nxt;
    qwsc_nv_word_t rd_val_r; // Value waiting to go out
    qwsc_nv_word_t rd_val_nxt;
    logic rd_pend_r; // Merge rd_val_r into the next frame
    logic rd_pend_nxt;

    // Slot store access
    logic [3:0] nv_rd_addr;
    qwsc_nv_word_t nv_rd_data;
    logic nv_wr_en;
    logic [3:0] nv_wr_addr;
    qwsc_nv_word_t nv_wr_data;

    // Link side
    qwsc_frame_t frame;
    logic frame_full;
    logic frame_end;
    logic wp_active;
    qwsc_nv_word_t cur_word;

    // Slot address: slot index above channel index
    function automatic logic [3:0] slot_addr(input logic [1:0] slot, input logic [1:0] chan);
        slot_addr = {slot, chan};
    endfunction

    // Saturating one-step move of a wiper
    function automatic logic [7:0] step(input logic [7:0] val, input logic up);
        if (up) begin
            step = (val == WIPER_MAX) ? val : val + 8'h01;
        end else begin
            step = (val == WIPER_MIN) ? val : val - 8'h01;
        end
    endfunction

    // Link domain shifter
    qwsc_link u_link (
        .i_spi_clk(i_spi_clk),
        .i_reset(i_reset),
        .i_cs_n(i_cs_n),
        .i_sdi(i_sdi),
        .i_preload_en(rd_pend_r),
        .i_preload(rd_val_r),
        .o_frame(frame),
        .o_full(frame_full),
        .o_sdo_o(o_sdo_o),
        .o_sdo_oe(o_sdo_oe)
    );

    // Retained slots
    qwsc_nvstore u_nvstore (
        .i_sys_clk(i_sys_clk),
        .i_rd_addr(nv_rd_addr),
        .o_rd_data(nv_rd_data),
        .i_wr_en(nv_wr_en),
        .i_wr_addr(nv_wr_addr),
        .i_wr_data(nv_wr_data)
    );

    // Synchronise chip select and write protect
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r <= 1'b1;
            wp_s1_r <= 1'b1;
            wp_s2_r <= 1'b1;
        end else begin
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_d_r <= cs_s2_r;
            wp_s1_r <= i_wp_n;
            wp_s2_r <= wp_s1_r;
        end
    end

    // The serial clock is stopped once select rises, so the
    // frame word is stable by the time the synced edge arrives
    assign frame_end = cs_s2_r && !cs_d_r;
    assign wp_active = !wp_s2_r;
    assign cur_word = {bufm_r[frame.channel_sel], wiper_r[frame.channel_sel]};

    // Read address: boot walk uses slot 0, otherwise the frame's slot
    always_comb begin
        if (state_r == ST_BOOT) begin
            nv_rd_addr = slot_addr(2'b00, boot_idx_r);
        end else begin
            nv_rd_addr = slot_addr(frame.slot_sel, frame.channel_sel);
        end
    end

    // Next-state logic of the command engine
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        boot_idx_nxt = boot_idx_r;
        wiper_nxt = wiper_r;
        bufm_nxt = bufm_r;
        asleep_nxt = asleep_r;
        rd_val_nxt = rd_val_r;
        rd_pend_nxt = rd_pend_r;
        nv_wr_en = 1'b0;
        nv_wr_addr = slot_addr(frame.slot_sel, frame.channel_sel);
        nv_wr_data = {frame.buffer_mode_bit, frame.wiper_data_byte};
        case (state_r)
            // Recall slot 0 into every channel, one per cycle
            ST_BOOT: begin
                wiper_nxt[boot_idx_r] = nv_rd_data.wiper_data_byte;
                bufm_nxt[boot_idx_r] = nv_rd_data.buffer_mode_bit;
                boot_idx_nxt = boot_idx_r + 2'b01;
                if (boot_idx_r == 2'b11) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (frame_end) begin
                    // Any new frame consumes a pending read value
                    rd_pend_nxt = 1'b0;
                end
                // Short frames are dropped whole
                if (frame_end && frame_full) begin
                    if (asleep_r) begin
                        // Only wake is heard while asleep
                        if (frame.opcode_field == OP_WAKE) begin
                            asleep_nxt = 1'b0;
                        end
                    end else begin
                        case (frame.opcode_field)
                            OP_NOP: begin
                                asleep_nxt = 1'b0;
                            end
                            OP_WAKE: begin
                                asleep_nxt = 1'b0;
                            end
                            OP_SLEEP: begin
                                asleep_nxt = 1'b1;
                            end
                            OP_SWPOR: begin
                                // Back to the power-up state
                                asleep_nxt = 1'b1;
                                boot_idx_nxt = 2'b00;
                                state_nxt = ST_BOOT;
                            end
                            OP_WRITE: begin
                                // Buffer mode is left alone here
                                wiper_nxt[frame.channel_sel] = frame.wiper_data_byte;
                            end
                            OP_UP: begin
                                wiper_nxt[frame.channel_sel] = step(wiper_r[frame.channel_sel], 1'b1);
                            end
                            OP_DOWN: begin
                                wiper_nxt[frame.channel_sel] = step(wiper_r[frame.channel_sel], 1'b0);
                            end
                            OP_LOAD: begin
                                // Besides the boot recall, the only path that moves the buffer mode
                                wiper_nxt[frame.channel_sel] = nv_rd_data.wiper_data_byte;
                                bufm_nxt[frame.channel_sel] = nv_rd_data.buffer_mode_bit;
                                state_nxt = ST_ACCESS;
                            end
                            OP_RD_WIPER: begin
                                rd_val_nxt = cur_word;
                                rd_pend_nxt = 1'b1;
                                state_nxt = ST_ACCESS;
                            end
                            OP_RD_SLOT: begin
                                rd_val_nxt = nv_rd_data;
                                rd_pend_nxt = 1'b1;
                                state_nxt = ST_ACCESS;
                            end
                            OP_PROG: begin
                                nv_wr_en = !wp_active;
                                state_nxt = ST_ACCESS;
                            end
                            OP_SAVE: begin
                                nv_wr_data = cur_word;
                                nv_wr_en = !wp_active;
                                state_nxt = ST_ACCESS;
                            end
                            OP_ERASE: begin
                                nv_wr_data = NV_ERASED;
                                nv_wr_en = !wp_active;
                                state_nxt = ST_ACCESS;
                            end
                            default: begin
                                // Undefined opcodes do nothing
                                state_nxt = ST_IDLE;
                            end
                        endcase
                    end
                end
                cnt_nxt = 8'h00;
            end
            // Frames arriving now are ignored; the host polls ready
            ST_ACCESS: begin
                if (frame_end) begin
                    rd_pend_nxt = 1'b0;
                end
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == ACCESS_LAST) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Ready follows the next state so it drops on the frame's
        // execution edge and rises when the access finishes
        ready_nxt = (state_nxt == ST_IDLE);
    end

    // Register the engine state
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= ST_BOOT;
            cnt_r <= 8'h00;
            boot_idx_r <= 2'b00;
            wiper_r <= {NUM_CHAN{WIPER_RESET}};
            bufm_r <= 4'h0;
            asleep_r <= 1'b1;
            ready_r <= 1'b0;
            rd_val_r <= NV_ERASED;
            rd_pend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            boot_idx_r <= boot_idx_nxt;
            wiper_r <= wiper_nxt;
            bufm_r <= bufm_nxt;
            asleep_r <= asleep_nxt;
            ready_r <= ready_nxt;
            rd_val_r <= rd_val_nxt;
            rd_pend_r <= rd_pend_nxt;
        end
    end

    // Outputs straight from flops
    assign o_ready = ready_r;
    assign o_asleep = asleep_r;
    assign o_wiper_value = wiper_r;
    assign o_buffer_on = bufm_r;
endmodule

// File: qwsc_core_monitor.sv
// Watches the top level ports of the wiper command engine
module qwsc_core_monitor
    import qwsc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_spi_clk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_wp_n,
    input wire logic o_sdo_o,
    input wire logic o_sdo_oe,
    input wire logic o_ready,
    input wire logic o_asleep,
    input wire logic [31:0] o_wiper_value,
    input wire logic [3:0] o_buffer_on
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] low_cnt_r; // Cycles spent not ready
    logic [7:0] low_cnt_nxt;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    // Count the busy stretch; saturates so a stuck flag cannot wrap to a legal figure
    always_comb begin
        if (o_ready) begin
            low_cnt_nxt = 8'h00;
        end else if (low_cnt_r != 8'hFF) begin
            low_cnt_nxt = low_cnt_r + 8'h01;
        end else begin
            low_cnt_nxt = low_cnt_r;
        end
    end

    // Register the count
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= low_cnt_nxt;
        end
    end

    // Select held low long enough that no frame can be executing
    sequence s_cs_low_run;
        !i_cs_n [*5];
    endsequence

    a_sdo_drive_zero: assert property (o_sdo_o == 1'b0)
        else $error("data out drives a one");
    a_sdo_idle_release: assert property (i_cs_n |-> !o_sdo_oe)
        else $error("data out pulled while deselected");
    a_busy_length: assert property ($rose(o_ready) |-> low_cnt_r == 8'h04 || low_cnt_r == 8'(ACCESS_CYCLES))
        else $error("busy period has the wrong length");
    a_ready_at_select: assert property (o_ready && !i_cs_n |=> o_ready)
        else $error("ready dropped during a frame");
    a_asleep_frozen: assert property (o_asleep && o_ready |=> o_ready && $stable(o_wiper_value))
        else $error("asleep device acted on a command");
    a_buffer_only_load: assert property ($changed(o_buffer_on) |-> !o_ready || !$past(o_ready))
        else $error("buffer mode changed by a fast command");
    a_frame_no_exec: assert property (s_cs_low_run |-> $stable(o_wiper_value) && $stable(o_buffer_on))
        else $error("state changed inside a frame");
    a_exec_after_rise: assert property ($changed(o_wiper_value) && $past(o_ready)
        |-> $past(i_cs_n) && $past(i_cs_n, 2) && $past(i_cs_n, 3))
        else $error("wiper changed before select rose");
endmodule

bind qwsc_core qwsc_core_monitor u_mon (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_spi_clk(i_spi_clk),
    .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_wp_n(i_wp_n), .o_sdo_o(o_sdo_o), .o_sdo_oe(o_sdo_oe),
    .o_ready(o_ready), .o_asleep(o_asleep), .o_wiper_value(o_wiper_value), .o_buffer_on(o_buffer_on));

// File: qwsc_host.sv
// Host side of the serial port; clock only runs inside frames
module qwsc_host (
    input wire logic i_sdo_line,
    output logic o_spi_clk,
    output logic o_cs_n,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle levels: deselected, clock parked low
    initial begin
        o_spi_clk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end

    // Shift nbits out of tx, most significant first, capturing data out on rising edges
    task automatic xfer(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
        rx = 48'h0;
        o_cs_n = 1'b0;
        #3;
        for (int i = nbits - 1; i >= 0; i--) begin
            o_sdi = tx[i];
            #3;
            o_spi_clk = 1'b1;
            rx = {rx[46:0], i_sdo_line};
            #3;
            o_spi_clk = 1'b0;
        end
        #3;
        o_cs_n = 1'b1;
        // Flip the released data line so a stale level cannot pass for a sample
        o_sdi = ~o_sdi;
    endtask
endmodule

// File: qwsc_core_tb.sv
// Self-checking bench for the wiper command engine
module qwsc_core_tb;
    import qwsc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk, i_reset, i_wp_n;
    logic spi_clk, cs_n, sdi, sdo_o, sdo_oe, ready, asleep;
    logic [31:0] wiper;
    logic [3:0] buf_on;
    logic [47:0] rx; // Bits captured in the last transfer
    int mismatches, checks_done;
    wire sdo_line = sdo_oe ? sdo_o : 1'b1; // Pull-up when nobody pulls low

    qwsc_core u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_spi_clk(spi_clk), .i_cs_n(cs_n),
        .i_sdi(sdi), .i_wp_n(i_wp_n), .o_sdo_o(sdo_o), .o_sdo_oe(sdo_oe), .o_ready(ready),
        .o_asleep(asleep), .o_wiper_value(wiper), .o_buffer_on(buf_on));
    qwsc_host u_host (.i_sdo_line(sdo_line), .o_spi_clk(spi_clk), .o_cs_n(cs_n), .o_sdi(sdi));

    // System clock, 100 MHz
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // Verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded poll of the ready flag; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (ready !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask

    // Build one frame from its fields
    function automatic logic [23:0] frm(logic [3:0] op, logic [1:0] s, logic [1:0] c, logic [8:0] d);
        qwsc_frame_t f;
        f = '0;
        f.opcode_field = op;
        f.slot_sel = s;
        f.channel_sel = c;
        f.buffer_mode_bit = d[8];
        f.wiper_data_byte = d[7:0];
        return f;
    endfunction

    // Transfer, let it execute, then wait out any busy period
    task automatic xfer_wait(input logic [47:0] tx, input int nbits);
        @(negedge i_sys_clk);
        u_host.xfer(tx, nbits, rx);
        repeat (6) @(negedge i_sys_clk);
        wait_ready();
    endtask

    task automatic send(input logic [23:0] f);
        xfer_wait({24'h0, f}, 24);
    endtask

    // A read answer leaves in the low nine bits of the following frame
    task automatic rd_check(input logic [3:0] op, input logic [1:0] s, input logic [1:0] c, input logic [8:0] e);
        logic [23:0] f;
        f = frm(op, s, c, 9'h000);
        send(f);
        send(frm(OP_NOP, 2'h0, 2'h0, 9'h000));
        check(rx, {24'h0, f[23:9], e});
    endtask

    initial begin
        mismatches = 0;
        checks_done = 0;
        i_reset = 1'b1;
        i_wp_n = 1'b1;
        repeat (16) @(negedge i_sys_clk);
        i_reset = 1'b0;
        wait_ready();
        check(asleep, 48'h1);
        check(wiper, 48'h0);
        send(frm(OP_WRITE, 2'h0, 2'h0, 9'h055));
        check(wiper, 48'h0);
        send(frm(OP_WAKE, 2'h0, 2'h0, 9'h000));
        check(asleep, 48'h0);
        // Direct writes to every channel, buffer bit set but ignored
        for (int c = 0; c < 4; c++) begin
            send(frm(OP_WRITE, 2'h0, 2'(c), {1'b1, 8'(8'h10 + c)}));
        end
        check(wiper, 48'h13121110);
        check(buf_on, 48'h0);
        // Steps stop at both ends of the scale
        send(frm(OP_WRITE, 2'h0, 2'h1, 9'h0FE));
        send(frm(OP_WRITE, 2'h0, 2'h2, 9'h001));
        for (int k = 0; k < 2; k++) begin
            send(frm(OP_UP, 2'h0, 2'h1, 9'h000));
            send(frm(OP_DOWN, 2'h0, 2'h2, 9'h000));
        end
        check(wiper[23:8], {8'h00, WIPER_MAX});
        send(frm(OP_PROG, 2'h2, 2'h3, 9'h1A5));
        send(frm(OP_LOAD, 2'h2, 2'h3, 9'h000));
        check(wiper[31:24], 48'hA5);
        check(buf_on, 48'h8);
        rd_check(OP_RD_SLOT, 2'h2, 2'h3, 9'h1A5);
        rd_check(OP_RD_WIPER, 2'h0, 2'h3, 9'h1A5);
        send(frm(OP_SAVE, 2'h1, 2'h1, 9'h000));
        rd_check(OP_RD_SLOT, 2'h1, 2'h1, 9'h0FF);
        // Protected: slot changes blocked, load still works
        i_wp_n = 1'b0;
        send(frm(OP_PROG, 2'h1, 2'h1, 9'h033));
        send(frm(OP_ERASE, 2'h1, 2'h1, 9'h000));
        send(frm(OP_WRITE, 2'h0, 2'h3, 9'h000));
        send(frm(OP_LOAD, 2'h2, 2'h3, 9'h000));
        check(wiper[31:24], 48'hA5);
        rd_check(OP_RD_SLOT, 2'h1, 2'h1, 9'h0FF);
        i_wp_n = 1'b1;
        send(frm(OP_ERASE, 2'h1, 2'h1, 9'h000));
        rd_check(OP_RD_SLOT, 2'h1, 2'h1, NV_ERASED);
        // Two-device chain: far frame comes out, near frame stays
        xfer_wait({24'h5A3C96, frm(OP_WRITE, 2'h0, 2'h0, 9'h077)}, 48);
        check(rx, 48'h5A3C96);
        check(wiper[7:0], 48'h77);
        // A short frame is refused
        xfer_wait({24'h0, frm(OP_WRITE, 2'h0, 2'h0, 9'h011)}, 12);
        check(wiper[7:0], 48'h77);
        send(frm(OP_PROG, 2'h0, 2'h2, 9'h042));
        send(frm(OP_SLEEP, 2'h0, 2'h0, 9'h000));
        send(frm(OP_WRITE, 2'h0, 2'h2, 9'h0AA));
        check({asleep, wiper[23:16]}, 48'h100);
        send(frm(OP_WAKE, 2'h0, 2'h0, 9'h000));
        send(frm(OP_SWPOR, 2'h0, 2'h0, 9'h000));
        check(wiper, 48'h00420000);
        check({asleep, buf_on}, 48'h10);
        end_sim();
    end
endmodule
